//--- logic/opt_pkg.sv
// constants and types for the option and timebase register bank
package opt_pkg;
  localparam int ADDR_W = 12;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DIV_HIGH = 8'h01;
  localparam logic [7:0] IDX_DIV_LOW = 8'h02;
  localparam logic [7:0] IDX_ARRAY_CFG = 8'h03;
  localparam logic [7:0] IDX_NV_ARRAY = 8'h04;
  localparam logic [7:0] IDX_NV_DIV_HIGH = 8'h05;
  localparam logic [7:0] IDX_NV_DIV_LOW = 8'h06;
  localparam logic [7:0] IDX_LATCH_CTRL = 8'h07;
  localparam logic [7:0] IDX_NV_CMD = 8'h08;
  localparam logic [7:0] IDX_SYSTEM_OPTIONS_FIRST = 8'h1F;
  localparam logic [7:0] IDX_SYSTEM_OPTIONS_SECOND = 8'h3F;
  // divisor high byte layout
  localparam int SECD_BIT = 7;
  localparam logic [7:0] DIV_HIGH_MASK = 8'h87;
  // first configuration register fields
  localparam int WDOG_DIS_BIT = 0;
  localparam int STOP_EN_BIT = 1;
  localparam int WDOG_RATE_BIT = 2;
  localparam int SHORT_REC_BIT = 3;
  localparam int MON_PWRD_BIT = 4;
  localparam int MON_RSTD_BIT = 5;
  localparam int MON_STOP_BIT = 6;
  localparam logic [7:0] CFG1_MASK = 8'h7F;
  // second configuration register fields
  localparam int DIV_CLK_SEL_BIT = 0;
  localparam logic [7:0] CFG2_MASK = 8'h01;
  // non-volatile command fields
  localparam int CMD_OP_LSB = 8;
  localparam int CMD_TGT_LSB = 10;
  localparam logic [1:0] OP_ERASE = 2'h1;
  localparam logic [1:0] OP_PROGRAM = 2'h2;
  localparam logic [1:0] TGT_ARRAY = 2'h0;
  localparam logic [1:0] TGT_DIV_HIGH = 2'h1;
  localparam logic [1:0] TGT_DIV_LOW = 2'h2;
  // factory contents of the non-volatile bytes
  localparam logic [7:0] NV_ARRAY_FACTORY = 8'h10;
  localparam logic [7:0] NV_DIV_HIGH_FACTORY = 8'h80;
  localparam logic [7:0] NV_DIV_LOW_FACTORY = 8'h00;
  localparam logic [7:0] NV_ERASED = 8'hFF;
  // stop recovery and watchdog timeouts in crystal cycles
  localparam logic [12:0] STOP_REC_SHORT = 13'h0020;
  localparam logic [12:0] STOP_REC_LONG = 13'h1000;
  localparam logic [17:0] WDOG_LONG = 18'h3FFF0;
  localparam logic [17:0] WDOG_SHORT = 18'h01FF0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum {SEL_NONE, SEL_DIV_HIGH, SEL_DIV_LOW, SEL_ARRAY_CFG, SEL_NV_ARRAY,
    SEL_NV_DIV_HIGH, SEL_NV_DIV_LOW, SEL_LATCH, SEL_NV_CMD, SEL_CFG1, SEL_CFG2} reg_sel_t;
endpackage

//--- logic/tb_if.sv
// carrier between the register bank and the timebase divider
`timescale 1ns/10ps
`default_nettype none
interface tb_if;
  logic [10:0] divisor;
  logic use_bus_clk;
  logic xtal_edge;
  logic tick;
  modport ctrl (output divisor, output use_bus_clk, output xtal_edge, input tick);
  modport div (input divisor, input use_bus_clk, input xtal_edge, output tick);
endinterface
`default_nettype wire

//--- logic/timebase_divider.sv
// divider that turns reference events into the timebase tick
`timescale 1ns/10ps
`default_nettype none
module timebase_divider
  import opt_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  tb_if.div tb
);
  logic [10:0] count_q;
  logic tick_q;
  logic ref_event;
  logic [10:0] last_count;

  assign ref_event = tb.use_bus_clk | tb.xtal_edge;
  assign last_count = 11'(tb.divisor - 11'h001);

  // count reference events, tick and restart at the divisor
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      count_q <= 11'h000;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= 1'b0;
      if (ref_event && tb.divisor != 11'h000)
      begin
        if (count_q >= last_count)
        begin
          count_q <= 11'h000;
          tick_q <= 1'b1;
        end
        else
        begin
          count_q <= 11'(count_q + 11'h001);
        end
      end
    end
  end

  assign tb.tick = tick_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_tick_restarts: assert property (tb.tick |-> count_q == 11'h000 && $past(ref_event))
    else $error("tick without restart of the count");
  a_tick_needs_div: assert property (tb.divisor == 11'h000
    && $past(tb.divisor) == 11'h000 |-> !tb.tick)
    else $error("tick with zero divisor");
  a_busclk_period: assert property (tb.use_bus_clk && tb.divisor == 11'h002 && tb.tick
    && $stable(tb.divisor) ##1 tb.use_bus_clk && tb.divisor == 11'h002 |=> tb.tick)
    else $error("bus clock divider period wrong");
endmodule // timebase_divider
`default_nettype wire

//--- logic/option_regs.sv
// option, array configuration and timebase divisor registers on axi4-lite
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - every reset copies the array option byte into the read-only shadow
// - array option byte changes only by erase/program; factory value 0x10
// - 11-bit divisor in high and low bytes yields the 35 us tick
// - reset loads both divisor bytes from their non-volatile copies
// - security bit 0 locks divisor bytes and their non-volatile copies
// - divisor writable only with latch control 0 and security bit 1
// - clock-select 1 uses bus clock, 0 uses crystal clock
// - security bit programmed 0 reloads 0 on each reset, lock permanent
// - each configuration register takes one write per reset, always readable
// - reset clears both configuration registers
// - configuration registers sit at indices 0x1F and 0x3F
// - monitor runs in stop only with monitor-stop bit set and power not disabled
// - reset-disable 1 blocks monitor resets, 0 passes them
// - power-disable 1 removes monitor power
// - short recovery 1 gives 32 crystal cycles, 0 gives 4096
// - watchdog rate 1 gives 2^18-2^4 cycles, 0 gives 2^13-2^4
// - stop enable 0 makes STOP an illegal opcode
// - watchdog disable 1 turns the watchdog off
module option_regs
  import opt_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic nv_power_on,
  input wire logic crystal_clock,
  input wire logic monitor_reset_request,
  input wire logic stop_request,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic timebase_tick,
  output logic [7:0] array_configuration_shadow,
  output logic monitor_stop_active,
  output logic monitor_power_enable,
  output logic monitor_reset_out,
  output logic stop_illegal,
  output logic stop_execute,
  output logic watchdog_enable,
  output logic [12:0] stop_recovery_cycles,
  output logic [17:0] watchdog_timeout_cycles
);
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    if (a[1:0] != 2'h0 || a[ADDR_W-1:10] != '0) return SEL_NONE;
    else if (idx == IDX_DIV_HIGH) return SEL_DIV_HIGH;
    else if (idx == IDX_DIV_LOW) return SEL_DIV_LOW;
    else if (idx == IDX_ARRAY_CFG) return SEL_ARRAY_CFG;
    else if (idx == IDX_NV_ARRAY) return SEL_NV_ARRAY;
    else if (idx == IDX_NV_DIV_HIGH) return SEL_NV_DIV_HIGH;
    else if (idx == IDX_NV_DIV_LOW) return SEL_NV_DIV_LOW;
    else if (idx == IDX_LATCH_CTRL) return SEL_LATCH;
    else if (idx == IDX_NV_CMD) return SEL_NV_CMD;
    else if (idx == IDX_SYSTEM_OPTIONS_FIRST) return SEL_CFG1;
    else if (idx == IDX_SYSTEM_OPTIONS_SECOND) return SEL_CFG2;
    else return SEL_NONE;
  endfunction

  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q, rdata_d;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_go, wr_en;
  reg_sel_t wr_sel, rd_sel;
  logic [7:0] div_high_q, div_low_q, array_cfg_q;
  logic [7:0] nv_array_q, nv_div_high_q, nv_div_low_q;
  logic [7:0] cfg1_q, cfg2_q;
  logic cfg1_done_q, cfg2_done_q, latch_q;
  logic div_locked, div_write_ok, nv_cmd_go;
  logic [1:0] cmd_op, cmd_tgt;
  logic [7:0] cmd_data;
  logic xtal_meta_q, xtal_sync_q, xtal_prev_q;
  logic mon_rst_q, stop_ill_q, stop_exec_q;
  tb_if tbi ();

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_sel = decode(aw_addr_q);
  assign wr_en = wr_go && w_strb_q[0];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      end
      else if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // read channel: one read at a time, answer one cycle after address
  assign s_axi_arready = !rvalid_q;
  assign rd_sel = decode(s_axi_araddr);

  always_comb
  begin
    rdata_d = 32'h00000000;
    case (rd_sel)
      SEL_DIV_HIGH: rdata_d[7:0] = div_high_q;
      SEL_DIV_LOW: rdata_d[7:0] = div_low_q;
      SEL_ARRAY_CFG: rdata_d[7:0] = array_cfg_q;
      SEL_NV_ARRAY: rdata_d[7:0] = nv_array_q;
      SEL_NV_DIV_HIGH: rdata_d[7:0] = nv_div_high_q;
      SEL_NV_DIV_LOW: rdata_d[7:0] = nv_div_low_q;
      SEL_LATCH: rdata_d[0] = latch_q;
      SEL_CFG1: rdata_d[7:0] = cfg1_q;
      SEL_CFG2: rdata_d[7:0] = cfg2_q;
      default: rdata_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rdata_d;
      rresp_q <= (rd_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // divisor bytes: reloaded at reset, writes gated by lock and latch
  assign div_locked = !div_high_q[SECD_BIT];
  assign div_write_ok = !latch_q && !div_locked;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      div_high_q <= nv_div_high_q & DIV_HIGH_MASK;
      div_low_q <= nv_div_low_q;
      array_cfg_q <= nv_array_q;
    end
    else if (wr_en && div_write_ok)
    begin
      if (wr_sel == SEL_DIV_HIGH) div_high_q <= w_data_q[7:0] & DIV_HIGH_MASK;
      if (wr_sel == SEL_DIV_LOW) div_low_q <= w_data_q[7:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      latch_q <= 1'b0;
    end
    else if (wr_en && wr_sel == SEL_LATCH)
    begin
      latch_q <= w_data_q[0];
    end
  end

  // non-volatile bytes: erase sets ones, program clears bits
  assign cmd_op = w_data_q[CMD_OP_LSB +: 2];
  assign cmd_tgt = w_data_q[CMD_TGT_LSB +: 2];
  assign cmd_data = w_data_q[7:0];
  assign nv_cmd_go = wr_en && wr_sel == SEL_NV_CMD && latch_q
    && (cmd_tgt == TGT_ARRAY || !div_locked);

  always_ff @(posedge clk)
  begin
    if (nv_power_on)
    begin
      nv_array_q <= NV_ARRAY_FACTORY;
      nv_div_high_q <= NV_DIV_HIGH_FACTORY;
      nv_div_low_q <= NV_DIV_LOW_FACTORY;
    end
    else if (nv_cmd_go)
    begin
      case (cmd_tgt)
        TGT_ARRAY:
        begin
          if (cmd_op == OP_ERASE) nv_array_q <= NV_ERASED;
          else if (cmd_op == OP_PROGRAM) nv_array_q <= nv_array_q & cmd_data;
        end
        TGT_DIV_HIGH:
        begin
          if (cmd_op == OP_ERASE) nv_div_high_q <= NV_ERASED;
          else if (cmd_op == OP_PROGRAM) nv_div_high_q <= nv_div_high_q & cmd_data;
        end
        TGT_DIV_LOW:
        begin
          if (cmd_op == OP_ERASE) nv_div_low_q <= NV_ERASED;
          else if (cmd_op == OP_PROGRAM) nv_div_low_q <= nv_div_low_q & cmd_data;
        end
        default:
        begin
          nv_array_q <= nv_array_q;
        end
      endcase
    end
  end

  // configuration registers: cleared at reset, one write each
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfg1_q <= 8'h00;
      cfg2_q <= 8'h00;
      cfg1_done_q <= 1'b0;
      cfg2_done_q <= 1'b0;
    end
    else
    begin
      if (wr_en && wr_sel == SEL_CFG1 && !cfg1_done_q)
      begin
        cfg1_q <= w_data_q[7:0] & CFG1_MASK;
        cfg1_done_q <= 1'b1;
      end
      if (wr_en && wr_sel == SEL_CFG2 && !cfg2_done_q)
      begin
        cfg2_q <= w_data_q[7:0] & CFG2_MASK;
        cfg2_done_q <= 1'b1;
      end
    end
  end

  // crystal clock pin sampled on the bus clock
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      xtal_meta_q <= 1'b0;
      xtal_sync_q <= 1'b0;
      xtal_prev_q <= 1'b0;
    end
    else
    begin
      xtal_meta_q <= crystal_clock;
      xtal_sync_q <= xtal_meta_q;
      xtal_prev_q <= xtal_sync_q;
    end
  end

  assign tbi.divisor = {div_high_q[2:0], div_low_q};
  assign tbi.use_bus_clk = cfg2_q[DIV_CLK_SEL_BIT];
  assign tbi.xtal_edge = !cfg2_q[DIV_CLK_SEL_BIT] && xtal_sync_q && !xtal_prev_q;

  timebase_divider u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .tb(tbi.div)
  );

  assign timebase_tick = tbi.tick;

  // gated system controls, registered
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mon_rst_q <= 1'b0;
      stop_ill_q <= 1'b0;
      stop_exec_q <= 1'b0;
    end
    else
    begin
      mon_rst_q <= monitor_reset_request && !cfg1_q[MON_RSTD_BIT];
      stop_ill_q <= stop_request && !cfg1_q[STOP_EN_BIT];
      stop_exec_q <= stop_request && cfg1_q[STOP_EN_BIT];
    end
  end

  assign array_configuration_shadow = array_cfg_q;
  assign monitor_stop_active = cfg1_q[MON_STOP_BIT] && !cfg1_q[MON_PWRD_BIT];
  assign monitor_power_enable = !cfg1_q[MON_PWRD_BIT];
  assign monitor_reset_out = mon_rst_q;
  assign stop_illegal = stop_ill_q;
  assign stop_execute = stop_exec_q;
  assign watchdog_enable = !cfg1_q[WDOG_DIS_BIT];
  assign stop_recovery_cycles = cfg1_q[SHORT_REC_BIT] ? STOP_REC_SHORT : STOP_REC_LONG;
  assign watchdog_timeout_cycles = cfg1_q[WDOG_RATE_BIT] ? WDOG_LONG : WDOG_SHORT;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_cfg_write_once: assert property (cfg1_done_q |=> $stable(cfg1_q))
    else $error("configuration register changed after its one write");
  a_cfg_reset_clear: assert property ($past(sys_rst)
    |-> cfg1_q == 8'h00 && cfg2_q == 8'h00 && !cfg1_done_q)
    else $error("configuration not cleared by reset");
  a_shadow_loaded: assert property ($past(sys_rst)
    |-> array_cfg_q == $past(nv_array_q) && div_low_q == $past(nv_div_low_q))
    else $error("shadow not loaded from non-volatile byte");
  a_div_lock_hold: assert property (div_locked
    |=> $stable(div_high_q) && $stable(div_low_q))
    else $error("locked divisor changed");
  a_div_latch_gate: assert property (latch_q && !$past(sys_rst) |-> $stable(div_low_q))
    else $error("divisor written while latch set");
  a_nv_lock_guard: assert property (div_locked && !nv_power_on
    |=> $stable(nv_div_high_q) && $stable(nv_div_low_q))
    else $error("locked non-volatile divisor copy altered");
  a_mon_reset_gate: assert property (monitor_reset_request && cfg1_q[MON_RSTD_BIT]
    |=> !monitor_reset_out)
    else $error("monitor reset passed while disabled");
  a_stop_illegal: assert property (stop_request && !cfg1_q[STOP_EN_BIT] ##1 1'b1
    |-> stop_illegal && !stop_execute)
    else $error("stop not flagged illegal");
  a_write_answer: assert property (wr_go |=> s_axi_bvalid && !s_axi_awready)
    else $error("write response missing");
endmodule // option_regs
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the option and timebase register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import opt_pkg::*;
;
  logic clk = 1'b0;
  logic crystal_clock = 1'b0;
  logic sys_rst, nv_power_on, monitor_reset_request, stop_request;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic timebase_tick, monitor_stop_active, monitor_power_enable, monitor_reset_out;
  logic stop_illegal, stop_execute, watchdog_enable;
  logic [7:0] array_configuration_shadow;
  logic [12:0] stop_recovery_cycles;
  logic [17:0] watchdog_timeout_cycles;
  logic [1:0] xc = 2'h0;
  logic [7:0] v, r, d;
  logic [10:0] k;
  localparam int BUS_HZ = 10_000_000;
  int bad_count = 0;
  int tests_run = 0;
  int g;

  option_regs i_option_regs (.clk, .sys_rst, .nv_power_on, .crystal_clock,
    .monitor_reset_request, .stop_request, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timebase_tick,
    .array_configuration_shadow, .monitor_stop_active, .monitor_power_enable,
    .monitor_reset_out, .stop_illegal, .stop_execute, .watchdog_enable,
    .stop_recovery_cycles, .watchdog_timeout_cycles);

  always #50 clk = ~clk;

  // crystal toggles every 4 bus clocks: one rising edge per 8 clocks
  always @(posedge clk)
  begin
    xc <= xc + 2'h1;
    if (xc == 2'h3)
      crystal_clock <= ~crystal_clock;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  // divisor for a reference clock in hertz, rounded to nearest
  function automatic logic [10:0] div_for(input int hz);
    return 11'((hz * 35 + 500_000) / 1_000_000);
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] dt, input logic [3:0] st,
    input logic [1:0] er);
    int n;
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd) && n < 50)
    begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1)
      begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1)
      begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do
    begin
      @(posedge clk);
      n++;
    end
    while (s_axi_bvalid !== 1'b1 && n < 100);
    s_axi_bready <= 1'b0;
    if (n >= 100)
      bad_count++;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e,
    input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (s_axi_arready !== 1'b1 && n < 50);
    s_axi_arvalid <= 1'b0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (s_axi_rvalid !== 1'b1 && n < 100);
    s_axi_rready <= 1'b0;
    if (n >= 100)
      bad_count++;
    chk(nm, e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask

  // option outputs for a loaded first configuration value
  task automatic cfg_out(input logic [7:0] c);
    chk("mon_stop", {31'h0, c[MON_STOP_BIT] & ~c[MON_PWRD_BIT]}, {31'h0, monitor_stop_active});
    chk("mon_pwr", {31'h0, ~c[MON_PWRD_BIT]}, {31'h0, monitor_power_enable});
    chk("wdog_en", {31'h0, ~c[WDOG_DIS_BIT]}, {31'h0, watchdog_enable});
    chk("stop_rec", c[SHORT_REC_BIT] ? 32'h20 : 32'h1000, {19'h0, stop_recovery_cycles});
    chk("wdog_to", c[WDOG_RATE_BIT] ? 32'h3FFF0 : 32'h1FF0, {14'h0, watchdog_timeout_cycles});
    stop_request <= 1'b1;
    monitor_reset_request <= 1'b1;
    @(posedge clk);
    stop_request <= 1'b0;
    monitor_reset_request <= 1'b0;
    @(posedge clk);
    chk("stop_exec", {31'h0, c[STOP_EN_BIT]}, {31'h0, stop_execute});
    chk("stop_ill", {31'h0, ~c[STOP_EN_BIT]}, {31'h0, stop_illegal});
    chk("mon_rst", {31'h0, ~c[MON_RSTD_BIT]}, {31'h0, monitor_reset_out});
  endtask

  // cycles between two consecutive ticks
  task automatic tick_gap(output int gp);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (timebase_tick !== 1'b1 && n < 5000);
    gp = 0;
    do
    begin
      @(posedge clk);
      gp++;
    end
    while (timebase_tick !== 1'b1 && gp < 5000);
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end

  initial
  begin
    {monitor_reset_request, stop_request} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    sys_rst = 1'b1;
    nv_power_on = 1'b1;
    v = 8'($urandom(32'h3A65));
    // short recovery set only while the bus clock drives the divider
    v = 8'($urandom) | 8'(1 << SHORT_REC_BIT);
    r = 8'($urandom);
    d = 8'(3 + $urandom % 16);
    repeat (2) @(posedge clk);
    nv_power_on <= 1'b0;
    sys_rst <= 1'b0;
    @(posedge clk);
    rdc("cfg1", 12'h07C, 32'h0, RESP_OKAY);
    rdc("cfg2", 12'h0FC, 32'h0, RESP_OKAY);
    rdc("div_high", 12'h004, 32'h80, RESP_OKAY);
    rdc("div_low", 12'h008, 32'h0, RESP_OKAY);
    rdc("shadow", 12'h00C, 32'h10, RESP_OKAY);
    chk("shadow_pin", 32'h10, {24'h0, array_configuration_shadow});
    rdc("unmapped", 12'h300, 32'h0, RESP_DECERR);
    wr(12'h07E, 32'hFF, 4'hF, RESP_DECERR);
    // a write without the low strobe leaves the one write unused
    wr(12'h0FC, 32'h1, 4'h0, RESP_OKAY);
    wr(12'h0FC, 32'h1, 4'h1, RESP_OKAY);
    wr(12'h0FC, 32'h0, 4'h1, RESP_OKAY);
    rdc("cfg2", 12'h0FC, 32'h1, RESP_OKAY);
    wr(12'h07C, {24'h0, v}, 4'hF, RESP_OKAY);
    wr(12'h07C, {24'h0, ~v}, 4'hF, RESP_OKAY);
    rdc("cfg1", 12'h07C, {24'h0, v & CFG1_MASK}, RESP_OKAY);
    cfg_out(v);
    wr(12'h004, 32'h80, 4'h1, RESP_OKAY);
    wr(12'h008, {24'h0, d}, 4'h1, RESP_OKAY);
    rdc("div_low", 12'h008, {24'h0, d}, RESP_OKAY);
    tick_gap(g);
    chk("bus_gap", {24'h0, d}, g);
    // corner: divisor two ticks every other bus clock
    wr(12'h008, 32'h2, 4'h1, RESP_OKAY);
    tick_gap(g);
    chk("gap_two", 32'h2, g);
    // divisor worked out for the bus clock frequency
    k = div_for(BUS_HZ);
    wr(12'h004, {24'h0, 1'b1, 4'h0, k[10:8]}, 4'h1, RESP_OKAY);
    wr(12'h008, {24'h0, k[7:0]}, 4'h1, RESP_OKAY);
    tick_gap(g);
    chk("ref_gap", {21'h0, k}, g);
    wr(12'h01C, 32'h1, 4'h1, RESP_OKAY);
    wr(12'h008, 32'h33, 4'h1, RESP_OKAY);
    rdc("div_low", 12'h008, {24'h0, k[7:0]}, RESP_OKAY);
    wr(12'h020, {20'h0, TGT_ARRAY, OP_PROGRAM, r}, 4'hF, RESP_OKAY);
    rdc("nv_array", 12'h010, {24'h0, r & 8'h10}, RESP_OKAY);
    chk("shadow_pin", 32'h10, {24'h0, array_configuration_shadow});
    wr(12'h020, {20'h0, TGT_DIV_LOW, OP_ERASE, 8'h00}, 4'hF, RESP_OKAY);
    wr(12'h020, {20'h0, TGT_DIV_HIGH, OP_ERASE, 8'h00}, 4'hF, RESP_OKAY);
    wr(12'h020, {20'h0, TGT_DIV_HIGH, OP_PROGRAM, 8'h01}, 4'hF, RESP_OKAY);
    rdc("nv_low", 12'h018, 32'hFF, RESP_OKAY);
    rdc("nv_high", 12'h014, 32'h01, RESP_OKAY);
    do_reset();
    rdc("cfg1", 12'h07C, 32'h0, RESP_OKAY);
    rdc("cfg2", 12'h0FC, 32'h0, RESP_OKAY);
    rdc("shadow", 12'h00C, {24'h0, r & 8'h10}, RESP_OKAY);
    rdc("div_high", 12'h004, 32'h01, RESP_OKAY);
    rdc("div_low", 12'h008, 32'hFF, RESP_OKAY);
    wr(12'h004, 32'h80, 4'h1, RESP_OKAY);
    wr(12'h008, 32'h00, 4'h1, RESP_OKAY);
    rdc("div_high", 12'h004, 32'h01, RESP_OKAY);
    rdc("div_low", 12'h008, 32'hFF, RESP_OKAY);
    wr(12'h01C, 32'h1, 4'h1, RESP_OKAY);
    wr(12'h020, {20'h0, TGT_DIV_HIGH, OP_ERASE, 8'h00}, 4'hF, RESP_OKAY);
    rdc("nv_high", 12'h014, 32'h01, RESP_OKAY);
    // complement of v keeps short recovery clear on the crystal
    wr(12'h07C, {24'h0, ~v}, 4'hF, RESP_OKAY);
    rdc("cfg1", 12'h07C, {24'h0, ~v & CFG1_MASK}, RESP_OKAY);
    cfg_out(~v);
    // divisor 0x1FF on crystal edges, one per 8 bus clocks: 0x1FF * 8 cycles
    tick_gap(g);
    chk("xtal_gap", 32'h00000FF8, g);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
